// ==== hw/gap_gpio_port.sv ====
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps

module gap_gpio_port #(
  parameter int INTERLOCK_CYCLES = gap_pkg::INTERLOCK_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [gap_pkg::ADDR_W-1:0] i_addr,
  input wire logic [gap_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [gap_pkg::DATA_W-1:0] o_rdata,
  input wire logic [gap_pkg::NUM_PINS-1:0] i_pin,
  output logic [gap_pkg::NUM_PINS-1:0] o_pin,
  output logic [gap_pkg::NUM_PINS-1:0] o_pin_oe_n,
  input wire gap_pkg::gap_light_s i_light,
  output gap_pkg::gap_light_s o_light,
  input wire logic i_bright_sample_hold,
  input wire gap_pkg::gap_aux_s i_aux,
  output logic o_aux_data_in,
  output logic o_park_micromirror_array,
  output logic o_primary_controller
);
  import gap_pkg::*;

  logic [2*NUM_PINS-1:0] mode_reg;
  logic [NUM_PINS-1:0] out_reg;
  logic [NUM_PINS-1:0] bidir_oe_reg;
  logic [ALT_W-1:0] alt_reg;
  logic [NUM_PINS-1:0] sync1_reg;
  logic [NUM_PINS-1:0] sync2_reg;
  logic [1:0] strap_cnt_reg;
  logic strap_done_reg;
  gap_ilk_e ilk_reg;
  gap_ilk_e ilk_next;
  logic [CNT_W-1:0] ilk_cnt_reg;
  logic [CNT_W-1:0] ilk_cnt_next;
  gap_drive_s drive_next [NUM_PINS];
  logic park_sel;
  logic permit_sel;
  logic sample_hold_sel;
  logic aux_sel;
  logic permit_level;
  logic forced;

  // direction decode for one pin in plain gpio use
  function automatic gap_drive_s pin_drive(input logic [1:0] mode,
                                           input logic val,
                                           input logic oe);
    gap_drive_s d;
    d.en = 1'b0;
    d.val = 1'b0;
    case (mode)
      MODE_OUTPUT: begin
        d.en = 1'b1;
        d.val = val;
      end
      MODE_BIDIR: begin
        d.en = oe;
        d.val = val;
      end
      MODE_OPEN_DRAIN: begin
        // only ever pulls low, the board pull-up gives the high
        d.en = ~val;
        d.val = 1'b0;
      end
      default: begin
        d.en = 1'b0;
        d.val = 1'b0;
      end
    endcase
    return d;
  endfunction

  // an output-only alternate function drives the pin steadily
  function automatic gap_drive_s alt_drive(input logic val);
    gap_drive_s d;
    d.en = 1'b1;
    d.val = val;
    return d;
  endfunction

  // write strobe decode for one register word
  function automatic logic wr_hit(input logic wr,
                                  input logic [ADDR_W-1:0] addr,
                                  input logic [ADDR_W-1:0] word);
    return wr && (addr == word);
  endfunction

  // every interlock state but released keeps the light off
  function automatic logic ilk_forced(input gap_ilk_e state);
    return state != ILK_RELEASED;
  endfunction

  // use decode of the two-bit pin 7 field
  function automatic logic pin7_is(input logic [ALT_W-1:0] alt,
                                   input logic [1:0] code);
    return alt[ALT_PIN7_LSB +: 2] == code;
  endfunction

  // alternate function selections
  assign park_sel = alt_reg[ALT_PARK_BIT];
  assign permit_sel = pin7_is(alt_reg, PIN7_PERMIT);
  assign sample_hold_sel = pin7_is(alt_reg, PIN7_SAMPLE_HOLD);
  assign aux_sel = alt_reg[ALT_AUX_BIT];
  assign permit_level = sync2_reg[PIN_PERMIT];

  // two-stage synchroniser on every pin; only stage two is ever read
  // a single stage could pass a metastable level into the logic
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_reg <= PINS_RESET;
      sync2_reg <= PINS_RESET;
    end else begin
      sync1_reg <= i_pin;
      sync2_reg <= sync1_reg;
    end
  end

  // direction mode register, all inputs after reset
  // write bits above the pin fields are dropped
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_reg <= MODE_RESET;
    end else if (wr_hit(i_wr, i_addr, ADDR_MODE)) begin
      mode_reg <= i_wdata[2*NUM_PINS-1:0];
    end
  end

  // output data register
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out_reg <= PINS_RESET;
    end else if (wr_hit(i_wr, i_addr, ADDR_OUT)) begin
      out_reg <= i_wdata[NUM_PINS-1:0];
    end
  end

  // driver enables for pins in bidirectional mode
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bidir_oe_reg <= PINS_RESET;
    end else if (wr_hit(i_wr, i_addr, ADDR_BIDIR_OE)) begin
      bidir_oe_reg <= i_wdata[NUM_PINS-1:0];
    end
  end

  // alternate function select register
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      alt_reg <= ALT_RESET;
    end else if (wr_hit(i_wr, i_addr, ADDR_ALT)) begin
      alt_reg <= i_wdata[ALT_W-1:0];
    end
  end

  // per-pin drive: gpio mode unless an alternate function owns the pin
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      drive_next[i] = pin_drive(mode_reg[2*i +: 2], out_reg[i],
                                bidir_oe_reg[i]);
    end
    // the strap pin is only ever sampled
    drive_next[PIN_STRAP] = '0;
    if (park_sel) begin
      drive_next[PIN_PARK] = '0;
    end
    if (permit_sel) begin
      drive_next[PIN_PERMIT] = '0;
    end else if (sample_hold_sel) begin
      drive_next[PIN_PERMIT] = alt_drive(i_bright_sample_hold);
    end
    // aux output pins follow the core one clock later; the data in pin is released
    if (aux_sel) begin
      drive_next[PIN_AUX_CS0] = alt_drive(i_aux.cs0_n);
      drive_next[PIN_AUX_CLOCK] = alt_drive(i_aux.clk);
      drive_next[PIN_AUX_DATA_OUT] = alt_drive(i_aux.dout);
      drive_next[PIN_AUX_DATA_IN] = '0;
    end
  end

  // pin outputs come from flops; enable is active low
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pin <= PINS_RESET;
      o_pin_oe_n <= ~PINS_RESET;
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        o_pin[i] <= drive_next[i].val;
        o_pin_oe_n[i] <= ~drive_next[i].en;
      end
    end
  end

  // interlock: forced while permit is low, held 100 ms after it rises
  always_comb begin
    ilk_next = ilk_reg;
    ilk_cnt_next = ilk_cnt_reg;
    if (!permit_sel) begin
      // without the interlock function the light outputs run free
      ilk_next = ILK_RELEASED;
      ilk_cnt_next = '0;
    end else if (!permit_level) begin
      // a low level at any point restarts the full hold time
      ilk_next = ILK_FORCED;
      ilk_cnt_next = '0;
    end else begin
      case (ilk_reg)
        ILK_FORCED: begin
          ilk_next = ILK_COUNTING;
          ilk_cnt_next = '0;
        end
        ILK_COUNTING: begin
          // counter width covers the full hold at the system clock
          if (ilk_cnt_reg == CNT_W'(INTERLOCK_CYCLES - 1)) begin
            ilk_next = ILK_RELEASED;
          end else begin
            ilk_cnt_next = ilk_cnt_reg + 1'b1;
          end
        end
        ILK_RELEASED: begin
          ilk_next = ILK_RELEASED;
        end
        default: begin
          ilk_next = ILK_FORCED;
          ilk_cnt_next = '0;
        end
      endcase
    end
  end

  // interlock state; reset loads forced, but it is released on the first clock unless pin 7 is set to permit
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ilk_reg <= ILK_FORCED;
      ilk_cnt_reg <= '0;
    end else begin
      ilk_reg <= ilk_next;
      ilk_cnt_reg <= ilk_cnt_next;
    end
  end

  // decoded from the next state so the outputs drop without a lag
  assign forced = ilk_forced(ilk_next);

  // light outputs, gated by the interlock
  // once released the core values pass through with one flop of delay
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_light.on <= 1'b0;
      o_light.sel <= SELECT_OFF;
    end else if (forced) begin
      o_light.on <= 1'b0;
      o_light.sel <= SELECT_OFF;
    end else begin
      o_light.on <= i_light.on;
      o_light.sel <= i_light.sel;
    end
  end

  // park request is a level to the mirror sequencer; the host keeps
  // each level 200 ms, so no filtering is needed here
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_park_micromirror_array <= 1'b0;
    end else begin
      // no power-down output exists: parking only
      o_park_micromirror_array <=
        park_sel & ~sync2_reg[PIN_PARK];
    end
  end

  // aux serial data in, returned only while the function is selected
  // held low when off so the core sees a quiet line
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_aux_data_in <= 1'b0;
    end else begin
      o_aux_data_in <= aux_sel & sync2_reg[PIN_AUX_DATA_IN];
    end
  end

  // strap caught once, after the synchroniser has filled
  // later strap changes are ignored until the next reset
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_cnt_reg <= '0;
      strap_done_reg <= 1'b0;
      o_primary_controller <= 1'b0;
    end else if (!strap_done_reg) begin
      if (strap_cnt_reg == STRAP_SETTLE) begin
        strap_done_reg <= 1'b1;
        o_primary_controller <= sync2_reg[PIN_STRAP];
      end else begin
        strap_cnt_reg <= strap_cnt_reg + 1'b1;
      end
    end
  end

  // read data stands only in the cycle after the read strobe
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else if (!i_rd) begin
      o_rdata <= '0;
    end else if (i_addr == ADDR_MODE) begin
      o_rdata <= DATA_W'(mode_reg);
    end else if (i_addr == ADDR_OUT) begin
      o_rdata <= DATA_W'(out_reg);
    end else if (i_addr == ADDR_BIDIR_OE) begin
      o_rdata <= DATA_W'(bidir_oe_reg);
    end else if (i_addr == ADDR_ALT) begin
      o_rdata <= DATA_W'(alt_reg);
    end else if (i_addr == ADDR_IN) begin
      o_rdata <= DATA_W'(sync2_reg);
    end else if (i_addr == ADDR_STATUS) begin
      o_rdata <= '0;
      o_rdata[ST_PARK_BIT] <= o_park_micromirror_array;
      // state, not next state: one cycle behind the light outputs
      o_rdata[ST_FORCED_BIT] <= ilk_forced(ilk_reg);
      o_rdata[ST_PRIMARY_BIT] <= o_primary_controller;
      o_rdata[ST_PERMIT_BIT] <= permit_level;
    end else begin
      // unmapped words read as zero
      o_rdata <= '0;
    end
  end

endmodule

// ==== hw/gap_pkg.sv ====
package gap_pkg;

  // pin count and pin positions of the alternate functions
  localparam int NUM_PINS = 9;
  localparam int PIN_AUX_DATA_IN = 0;
  localparam int PIN_AUX_CLOCK = 1;
  localparam int PIN_AUX_DATA_OUT = 2;
  localparam int PIN_AUX_CS0 = 3;
  localparam int PIN_STRAP = 4;
  localparam int PIN_PERMIT = 7;
  localparam int PIN_PARK = 8;

  // register bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // register word addresses
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_OUT = 4'h1;
  localparam logic [3:0] ADDR_BIDIR_OE = 4'h2;
  localparam logic [3:0] ADDR_ALT = 4'h3;
  localparam logic [3:0] ADDR_IN = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h5;

  // per-pin direction mode, two bits per pin in the mode register
  localparam logic [1:0] MODE_INPUT = 2'h0;
  localparam logic [1:0] MODE_OUTPUT = 2'h1;
  localparam logic [1:0] MODE_BIDIR = 2'h2;
  localparam logic [1:0] MODE_OPEN_DRAIN = 2'h3;

  // alternate function register fields
  localparam int ALT_PARK_BIT = 0;
  localparam int ALT_PIN7_LSB = 1;
  localparam int ALT_AUX_BIT = 3;
  localparam int ALT_W = 4;
  localparam logic [1:0] PIN7_GPIO = 2'h0;
  localparam logic [1:0] PIN7_PERMIT = 2'h1;
  localparam logic [1:0] PIN7_SAMPLE_HOLD = 2'h2;

  // status register fields
  localparam int ST_PARK_BIT = 0;
  localparam int ST_FORCED_BIT = 1;
  localparam int ST_PRIMARY_BIT = 2;
  localparam int ST_PERMIT_BIT = 3;

  // reset values
  localparam logic [17:0] MODE_RESET = 18'h00000;
  localparam logic [8:0] PINS_RESET = 9'h000;
  localparam logic [3:0] ALT_RESET = 4'h0;
  localparam logic [2:0] SELECT_OFF = 3'h0;

  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int INTERLOCK_MS = 100;
  localparam int PARK_MIN_LEVEL_MS = 200;
  localparam int INTERLOCK_CYCLES = INTERLOCK_MS * (CLK_HZ / 1000);
  localparam int CNT_W = 22;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  typedef enum logic [2:0] {
    ILK_FORCED = 3'b001,
    ILK_COUNTING = 3'b010,
    ILK_RELEASED = 3'b100
  } gap_ilk_e;

  typedef struct packed {
    logic on;
    logic [2:0] sel;
  } gap_light_s;

  typedef struct packed {
    logic cs0_n;
    logic clk;
    logic dout;
  } gap_aux_s;

  typedef struct packed {
    logic en;
    logic val;
  } gap_drive_s;

endpackage

// ==== verif/gap_gpio_port_assertions.sv ====
`timescale 1ns/1ps
// port-level checks; only relations visible at the pins are watched
module gap_gpio_port_assertions
  import gap_pkg::*;
#(
  parameter int INTERLOCK_CYCLES = 20
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic [NUM_PINS-1:0] i_pin,
  input wire logic [NUM_PINS-1:0] o_pin_oe_n,
  input wire gap_light_s i_light,
  input wire gap_light_s o_light,
  input wire logic o_aux_data_in,
  input wire logic o_park_micromirror_array,
  input wire logic o_primary_controller
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // a pad held for three edges has crossed both sync stages
  sequence park_high3;
    i_pin[PIN_PARK] [*3];
  endsequence
  sequence aux_low3;
    !i_pin[PIN_AUX_DATA_IN] [*3];
  endsequence
  rd_idle_zero_a:
    assert property (!i_rd |=> o_rdata == 32'h0)
    else $error("read data not zero outside a read");
  oe_cause_a:
    assert property ($changed(o_pin_oe_n) |-> $past(i_wr, 2))
    else $error("pad driver changed without a write");
  strap_input_a:
    assert property (o_pin_oe_n[PIN_STRAP])
    else $error("strap pad driven");
  primary_capture_a:
    assert property ($changed(o_primary_controller) |->
      o_primary_controller == $past(i_pin[PIN_STRAP], 3))
    else $error("primary flag differs from strap");
  park_cause_a:
    assert property (o_park_micromirror_array |-> !$past(i_pin[PIN_PARK], 3))
    else $error("park without low request");
  park_clear_a:
    assert property (park_high3 |=> !o_park_micromirror_array)
    else $error("park held with request high");
  light_gate_a:
    assert property (o_light == 4'h0 || o_light == $past(i_light))
    else $error("light outputs neither off nor core value");
  aux_in_a:
    assert property (aux_low3 |=> !o_aux_data_in)
    else $error("aux data in high with pad low");
endmodule

bind gap_gpio_port gap_gpio_port_assertions #(
  .INTERLOCK_CYCLES(INTERLOCK_CYCLES)
) i_gap_gpio_port_assertions (
  .i_core_clk(i_core_clk),
  .i_rst_n(i_rst_n),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .o_rdata(o_rdata),
  .i_pin(i_pin),
  .o_pin_oe_n(o_pin_oe_n),
  .i_light(i_light),
  .o_light(o_light),
  .o_aux_data_in(o_aux_data_in),
  .o_park_micromirror_array(o_park_micromirror_array),
  .o_primary_controller(o_primary_controller)
);

// ==== verif/gap_far_model.sv ====
`timescale 1ns/1ps
// host side of the pads; HOLD stands in for the long minimum level time
module gap_far_model
  import gap_pkg::*;
#(
  parameter int HOLD = 8
) (
  input wire logic i_core_clk,
  input wire logic i_park_req_n,
  input wire logic [NUM_PINS-1:0] i_level,
  input wire logic [NUM_PINS-1:0] i_drv,
  input wire logic [NUM_PINS-1:0] i_drv_oe_n,
  output logic [NUM_PINS-1:0] o_pad
);
  logic park_n_reg = 1'b1;
  int hold_reg = 0;
  // a park level may only change once the previous one was held long enough
  always_ff @(posedge i_core_clk) begin
    if (hold_reg < HOLD) begin
      hold_reg <= hold_reg + 1;
    end else if (i_park_req_n != park_n_reg) begin
      park_n_reg <= i_park_req_n;
      hold_reg <= 0;
    end
  end
  // released pads show the host level or the pull-up
  always_comb begin
    o_pad = i_level;
    o_pad[PIN_PARK] = park_n_reg;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (!i_drv_oe_n[i]) o_pad[i] = i_drv[i];
    end
  end
endmodule

// ==== verif/test_gap_gpio_port.sv ====
`timescale 1ns/1ps
module test_gap_gpio_port;
  import gap_pkg::*;
  localparam int ILK = 20;
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [ADDR_W-1:0] i_addr = 4'h0;
  logic [DATA_W-1:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [DATA_W-1:0] o_rdata;
  logic [NUM_PINS-1:0] i_pin, o_pin, o_pin_oe_n, exp_oe, exp_in;
  logic [NUM_PINS-1:0] level = 9'h17f;
  logic park_req_n = 1'b1;
  gap_light_s i_light = 4'hb;
  gap_light_s o_light;
  logic i_bright_sample_hold = 1'b0;
  gap_aux_s i_aux = 3'h0;
  logic o_aux_data_in, o_park_micromirror_array, o_primary_controller;
  int miscompares = 0;
  int compares = 0;

  always #25 i_core_clk = ~i_core_clk;

  gap_gpio_port #(.INTERLOCK_CYCLES(ILK)) i_gap_gpio_port (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_pin(i_pin), .o_pin(o_pin), .o_pin_oe_n(o_pin_oe_n),
    .i_light(i_light), .o_light(o_light),
    .i_bright_sample_hold(i_bright_sample_hold), .i_aux(i_aux),
    .o_aux_data_in(o_aux_data_in),
    .o_park_micromirror_array(o_park_micromirror_array),
    .o_primary_controller(o_primary_controller));

  gap_far_model i_gap_far_model (.i_core_clk(i_core_clk),
    .i_park_req_n(park_req_n), .i_level(level), .i_drv(o_pin),
    .i_drv_oe_n(o_pin_oe_n), .o_pad(i_pin));

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // bus cycles start on an edge; read data stand one cycle only
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic end_of_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge i_core_clk);
    miscompares++;
    end_of_test();
  end

  initial begin
    repeat (16) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    wt(6);
    chk(o_pin_oe_n, 9'h1ff);
    chk(o_primary_controller, 1'b1);
    for (int a = 0; a < 4; a++) rd(a[3:0], 32'h0);
    rd(ADDR_IN, 32'h17f);
    rd(ADDR_STATUS, 32'h4);
    wr(4'hf, 32'hffff_ffff);
    rd(4'hf, 32'h0);
    $display("reset test done");
    // every direction mode on all pins; pad levels read back
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_OUT, 32'h0a5);
      wr(ADDR_BIDIR_OE, 32'h0f0);
      wr(ADDR_MODE, {14'h0, {9{m[1:0]}}});
      wt(1);
      exp_oe = m == 0 ? 9'h1ff : m == 1 ? 9'h010 : m == 2 ? 9'h11f : 9'h0b5;
      chk(o_pin_oe_n, exp_oe);
      wt(2);
      exp_in = (exp_oe & level) | (~exp_oe & (m == 3 ? 9'h0 : 9'h0a5));
      rd(ADDR_IN, exp_in);
    end
    wr(ADDR_OUT, 32'h0);
    wr(ADDR_MODE, 32'h15555);
    wt(3);
    rd(ADDR_IN, 32'h010);
    wr(ADDR_MODE, 32'h0);
    $display("mode test done");
    wr(ADDR_ALT, 32'h1);
    @(posedge i_core_clk) park_req_n <= 1'b0;
    wt(12);
    chk(o_park_micromirror_array, 1'b1);
    rd(ADDR_STATUS, 32'h5);
    chk(o_light, i_light);
    @(posedge i_core_clk) park_req_n <= 1'b1;
    wt(12);
    chk(o_park_micromirror_array, 1'b0);
    wr(ADDR_ALT, 32'h0);
    @(posedge i_core_clk) park_req_n <= 1'b0;
    wt(12);
    chk(o_park_micromirror_array, 1'b0);
    $display("park test done");
    wr(ADDR_ALT, 32'h2);
    wt(4);
    chk(o_light, 4'h0);
    rd(ADDR_STATUS, 32'h6);
    @(posedge i_core_clk) level[PIN_PERMIT] <= 1'b1;
    wt(ILK);
    chk(o_light, 4'h0);
    wt(2);
    chk(o_light, 4'h0);
    wt(1);
    chk(o_light, i_light);
    wt(3);
    chk(o_light, i_light);
    @(posedge i_core_clk) i_light <= 4'h5;
    wt(2);
    chk(o_light, 4'h5);
    rd(ADDR_STATUS, 32'hc);
    @(posedge i_core_clk) level[PIN_PERMIT] <= 1'b0;
    wt(4);
    chk(o_light, 4'h0);
    wr(ADDR_ALT, 32'h0);
    wt(3);
    chk(o_light, 4'h5);
    wr(ADDR_ALT, 32'h4);
    for (int v = 0; v < 2; v++) begin
      @(posedge i_core_clk) i_bright_sample_hold <= v[0];
      wt(2);
      chk({o_pin_oe_n[PIN_PERMIT], o_pin[PIN_PERMIT]}, {1'b0, v[0]});
    end
    $display("light test done");
    // aux pads follow the core; data in comes back from pad 0
    wr(ADDR_ALT, 32'h8);
    for (int v = 0; v < 8; v++) begin
      @(posedge i_core_clk);
      i_aux <= v[2:0];
      level[PIN_AUX_DATA_IN] <= v[0];
      wt(3);
      chk({o_pin[3:1], o_pin_oe_n[3:0]}, {v[2], v[0], v[1], 4'h1});
      chk(o_aux_data_in, v[0]);
    end
    $display("aux test done");
    // second reset with the strap low
    @(posedge i_core_clk);
    level[PIN_STRAP] <= 1'b0;
    i_rst_n <= 1'b0;
    wt(16);
    @(posedge i_core_clk) i_rst_n <= 1'b1;
    wt(6);
    chk(o_primary_controller, 1'b0);
    chk(o_pin_oe_n, 9'h1ff);
    $display("strap test done");
    end_of_test();
  end
endmodule
